// *** rtl/power_mode_ctl.sv ***
// Behaviour
// - wait instruction with sleep select clear enters Idle
// - in Idle, only enabled interrupt above CPU priority resumes CPU
// - watchdog time-out or any reset also ends Idle
// - in Sleep, enabled sleep-capable interrupt above CPU priority wakes device
// - lower-or-equal priority sleep interrupt restarts peripheral clock, moves to Idle
// - any reset or watchdog time-out ends Sleep
// - Sleep halts CPU, system clock source and its peripherals
// - Idle halts only CPU clock; system source keeps running
// - peripherals with stop-in-idle set halt in Idle, others run
// - clock failure monitor off throughout Sleep
// - Sleep entry never clears watchdog; its count carries on
// - brown-out reset detector stays active in Sleep
// - pin change, watchdog, converter, serial, external or low-power-rc clocked blocks run in Sleep
// - Sleep wake may insert oscillator-dependent start-up delay
// - crystal/PLL source restart gets start-up and lock delay; Idle exit none
// - USB may keep primary or fast RC oscillator alive in Sleep
// - output pins keep driving their levels during Sleep
// - peripheral bus clock runs at programmable fraction of core clock
// - peripheral divider ratios one, two, four and eight
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module power_mode_ctl #(
  parameter int                                 NPERIPH        = 16,
  parameter logic [power_ctl_pkg::CNT_W-1:0]    FAST_RC_START_CYC =
    power_ctl_pkg::CNT_W'(power_ctl_pkg::FAST_RC_START_CYC),
  parameter logic [power_ctl_pkg::CNT_W-1:0]    LOW_RC_START_CYC  =
    power_ctl_pkg::CNT_W'(power_ctl_pkg::LOW_RC_START_CYC),
  parameter logic [power_ctl_pkg::CNT_W-1:0]    POSC_START_CYC =
    power_ctl_pkg::CNT_W'(power_ctl_pkg::POSC_START_CYC),
  parameter logic [power_ctl_pkg::CNT_W-1:0]    PLL_START_CYC  =
    power_ctl_pkg::CNT_W'(power_ctl_pkg::PLL_START_CYC)
) (
  // clock, reset, enable
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  input  wire logic                              ce,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [power_ctl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // cpu and interrupt controller
  input  wire logic                              wait_exec,
  input  wire logic [2:0]                        cpu_prio,
  input  wire power_ctl_pkg::wake_req_t          wake_req,
  // usb oscillator hold request
  input  wire logic                              usb_keep_osc,
  // clock and peripheral controls
  output power_ctl_pkg::clk_ctl_t                clk_ctl,
  output logic                                   pb_clk_tick,
  output logic      [NPERIPH-1:0]                periph_halt,
  output logic                                   cpu_release
);

  localparam int CW = power_ctl_pkg::CNT_W;

  // software state
  logic                                 sleep_select_bit;
  logic [power_ctl_pkg::PBDIV_W-1:0]    pb_div;
  logic                                 usb_ovr_en;
  power_ctl_pkg::osc_sel_t              osc_sel;
  logic [NPERIPH-1:0]                   stop_in_idle_bit;
  logic                                 next_sleep_select_bit;
  logic [power_ctl_pkg::PBDIV_W-1:0]    next_pb_div;
  logic                                 next_usb_ovr_en;
  power_ctl_pkg::osc_sel_t              next_osc_sel;
  logic [NPERIPH-1:0]                   next_stop_in_idle_bit;

  // bus answer state
  logic [31:0]                          next_prdata;
  logic                                 next_pready;
  logic                                 next_pslverr;

  // mode state
  power_ctl_pkg::power_state_t          state;
  power_ctl_pkg::power_state_t          next_state;
  logic [CW-1:0]                        wait_cnt;
  logic [CW-1:0]                        next_wait_cnt;
  logic                                 wake_to_run;
  logic                                 next_wake_to_run;
  logic                                 watchdog_wake;
  logic                                 next_watchdog_wake;
  power_ctl_pkg::clk_ctl_t              next_clk_ctl;
  logic [NPERIPH-1:0]                   next_periph_halt;
  logic                                 next_cpu_release;

  logic                                 prio_ok;
  logic                                 osc_kept;
  logic                                 bus_write;
  logic [31:0]                          ctrl_view;
  logic [31:0]                          status_view;

  function automatic logic [CW-1:0] startup_cycles(input power_ctl_pkg::osc_sel_t sel,
                                                   input logic kept);
    logic [CW-1:0] cyc;
    cyc = '0;
    if (!kept) begin
      case (sel)
        power_ctl_pkg::OSC_FAST_RC:  cyc = FAST_RC_START_CYC;
        power_ctl_pkg::OSC_LOW_RC:   cyc = LOW_RC_START_CYC;
        power_ctl_pkg::OSC_POSC:     cyc = POSC_START_CYC;
        default:                     cyc = PLL_START_CYC;
      endcase
    end
    return cyc;
  endfunction : startup_cycles

  // a request must strictly outrank the running code to wake it
  assign prio_ok   = wake_req.irq_valid && (wake_req.irq_prio > cpu_prio);

  // usb can only hold the primary or fast rc source, never the low-power rc
  assign osc_kept  = usb_ovr_en && usb_keep_osc && (osc_sel != power_ctl_pkg::OSC_LOW_RC);

  assign bus_write = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    ctrl_view                                                   = '0;
    ctrl_view[power_ctl_pkg::CTRL_SLEEP]                        = sleep_select_bit;
    ctrl_view[power_ctl_pkg::CTRL_PBDIV +: power_ctl_pkg::PBDIV_W] = pb_div;
    ctrl_view[power_ctl_pkg::CTRL_USBOVR]                       = usb_ovr_en;
    ctrl_view[power_ctl_pkg::CTRL_OSC +: 2]                     = osc_sel;
    status_view                                                 = '0;
    status_view[power_ctl_pkg::STAT_MODE +: 2]                  = state;
    status_view[power_ctl_pkg::STAT_BUSY]                       = (state == power_ctl_pkg::ST_WAKE_WAIT);
    status_view[power_ctl_pkg::STAT_WDTWAKE]                    = watchdog_wake;
  end

  // apb: data is registered in the setup cycle, so every transfer has one access cycle
  always_comb begin
    next_pready  = psel && !penable && !pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      if (paddr == power_ctl_pkg::OFS_CTRL) begin
        next_prdata = ctrl_view;
      end else if (paddr == power_ctl_pkg::OFS_STOP_IDLE) begin
        next_prdata = 32'(stop_in_idle_bit);
      end else if (paddr == power_ctl_pkg::OFS_STATUS) begin
        next_prdata = status_view;
      end else begin
        next_prdata  = '0;
        next_pslverr = 1'b1;
      end
    end else if (pready) begin
      next_prdata = '0;
    end
  end

  always_comb begin
    next_sleep_select_bit = sleep_select_bit;
    next_pb_div           = pb_div;
    next_usb_ovr_en       = usb_ovr_en;
    next_osc_sel          = osc_sel;
    next_stop_in_idle_bit = stop_in_idle_bit;
    if (bus_write) begin
      if (paddr == power_ctl_pkg::OFS_CTRL) begin
        next_sleep_select_bit = pwdata[power_ctl_pkg::CTRL_SLEEP];
        next_pb_div           = pwdata[power_ctl_pkg::CTRL_PBDIV +: power_ctl_pkg::PBDIV_W];
        next_usb_ovr_en       = pwdata[power_ctl_pkg::CTRL_USBOVR];
        next_osc_sel          = power_ctl_pkg::osc_sel_t'(pwdata[power_ctl_pkg::CTRL_OSC +: 2]);
      end else if (paddr == power_ctl_pkg::OFS_STOP_IDLE) begin
        next_stop_in_idle_bit = pwdata[NPERIPH-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata           <= '0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      sleep_select_bit <= power_ctl_pkg::CTRL_RESET[power_ctl_pkg::CTRL_SLEEP];
      pb_div           <= power_ctl_pkg::CTRL_RESET[power_ctl_pkg::CTRL_PBDIV +: power_ctl_pkg::PBDIV_W];
      usb_ovr_en       <= power_ctl_pkg::CTRL_RESET[power_ctl_pkg::CTRL_USBOVR];
      osc_sel          <= power_ctl_pkg::osc_sel_t'(power_ctl_pkg::CTRL_RESET[power_ctl_pkg::CTRL_OSC +: 2]);
      stop_in_idle_bit <= power_ctl_pkg::STOP_IDLE_RESET[NPERIPH-1:0];
    end else if (ce) begin
      prdata           <= next_prdata;
      pready           <= next_pready;
      pslverr          <= next_pslverr;
      sleep_select_bit <= next_sleep_select_bit;
      pb_div           <= next_pb_div;
      usb_ovr_en       <= next_usb_ovr_en;
      osc_sel          <= next_osc_sel;
      stop_in_idle_bit <= next_stop_in_idle_bit;
    end
  end

  // mode sequencing; any reset returns straight to run
  always_comb begin
    next_state       = state;
    next_wait_cnt    = wait_cnt;
    next_wake_to_run = wake_to_run;
    next_watchdog_wake = watchdog_wake;
    next_cpu_release = 1'b0;
    case (state)
      power_ctl_pkg::ST_RUN: begin
        if (wait_exec) begin
          if (sleep_select_bit) begin
            next_state = power_ctl_pkg::ST_SLEEP;
          end else begin
            next_state = power_ctl_pkg::ST_IDLE;
          end
        end
      end
      power_ctl_pkg::ST_IDLE: begin
        // the source never stopped, so leaving idle costs no start-up time
        if (wake_req.watchdog_timeout || prio_ok) begin
          next_state         = power_ctl_pkg::ST_RUN;
          next_cpu_release   = 1'b1;
          next_watchdog_wake = wake_req.watchdog_timeout;
        end
      end
      power_ctl_pkg::ST_SLEEP: begin
        if (wake_req.watchdog_timeout || (wake_req.irq_valid && wake_req.irq_in_sleep)) begin
          next_wake_to_run   = wake_req.watchdog_timeout || prio_ok;
          next_watchdog_wake = wake_req.watchdog_timeout;
          next_wait_cnt    = startup_cycles(osc_sel, osc_kept);
          if (startup_cycles(osc_sel, osc_kept) == '0) begin
            next_state       = next_wake_to_run ? power_ctl_pkg::ST_RUN : power_ctl_pkg::ST_IDLE;
            next_cpu_release = next_wake_to_run;
          end else begin
            next_state = power_ctl_pkg::ST_WAKE_WAIT;
          end
        end
      end
      default: begin
        // cpu stays gated until the oscillator has settled
        if (wait_cnt <= CW'(1)) begin
          next_wait_cnt    = '0;
          next_state       = wake_to_run ? power_ctl_pkg::ST_RUN : power_ctl_pkg::ST_IDLE;
          next_cpu_release = wake_to_run;
        end else begin
          next_wait_cnt = wait_cnt - CW'(1);
        end
      end
    endcase
  end

  // outputs follow the next mode so they change on the same edge as the state
  always_comb begin
    next_clk_ctl                 = '0;
    next_clk_ctl.cpu_clk_en      = (next_state == power_ctl_pkg::ST_RUN);
    next_clk_ctl.sys_osc_en      = (next_state != power_ctl_pkg::ST_SLEEP) || osc_kept;
    next_clk_ctl.pb_clk_run      = (next_state == power_ctl_pkg::ST_RUN) ||
                                   (next_state == power_ctl_pkg::ST_IDLE);
    next_clk_ctl.fail_mon_en     = (next_state == power_ctl_pkg::ST_RUN) ||
                                   (next_state == power_ctl_pkg::ST_IDLE);
    next_clk_ctl.brownout_en     = 1'b1;
    // watchdog and sleep-capable blocks are never stopped or cleared here
    next_clk_ctl.sleep_domain_en = 1'b1;
    next_clk_ctl.io_hold         = (next_state == power_ctl_pkg::ST_SLEEP) ||
                                   (next_state == power_ctl_pkg::ST_WAKE_WAIT);
  end

  always_comb begin
    case (next_state)
      power_ctl_pkg::ST_RUN:  next_periph_halt = '0;
      power_ctl_pkg::ST_IDLE: next_periph_halt = stop_in_idle_bit;
      default:                next_periph_halt = '1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                   <= power_ctl_pkg::ST_RUN;
      wait_cnt                <= '0;
      wake_to_run             <= 1'b0;
      watchdog_wake           <= 1'b0;
      cpu_release             <= 1'b0;
      clk_ctl                 <= '0;
      clk_ctl.cpu_clk_en      <= 1'b1;
      clk_ctl.sys_osc_en      <= 1'b1;
      clk_ctl.pb_clk_run      <= 1'b1;
      clk_ctl.fail_mon_en     <= 1'b1;
      clk_ctl.brownout_en     <= 1'b1;
      clk_ctl.sleep_domain_en <= 1'b1;
      periph_halt             <= '0;
    end else if (ce) begin
      state                   <= next_state;
      wait_cnt                <= next_wait_cnt;
      wake_to_run             <= next_wake_to_run;
      watchdog_wake           <= next_watchdog_wake;
      cpu_release             <= next_cpu_release;
      clk_ctl                 <= next_clk_ctl;
      periph_halt             <= next_periph_halt;
    end
  end

  // divider runs whenever the peripheral bus is clocked
  pb_clk_div #(
    .DIV_W (power_ctl_pkg::PBDIV_W),
    .CNT_W (power_ctl_pkg::PBCNT_W)
  ) u_pb_clk_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .run     (clk_ctl.pb_clk_run),
    .ratio   (pb_div),
    .tick    (pb_clk_tick)
  );

endmodule : power_mode_ctl

// *** rtl/power_ctl_pkg.sv ***
package power_ctl_pkg;

  // register map, byte addresses on the APB
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STOP_IDLE = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;

  // control register fields
  localparam int          CTRL_SLEEP   = 0;
  localparam int          CTRL_PBDIV   = 1;
  localparam int          CTRL_USBOVR  = 3;
  localparam int          CTRL_OSC     = 4;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] STOP_IDLE_RESET = 32'h0000_0000;

  // status register fields
  localparam int          STAT_MODE    = 0;
  localparam int          STAT_BUSY    = 2;
  localparam int          STAT_WDTWAKE = 3;

  // divider codes 0..3 give system to peripheral ratios 1:1, 1:2, 1:4, 1:8
  localparam int          PBDIV_W      = 2;
  localparam int          PBCNT_W      = 3;

  // start-up timing
  localparam int          CLK_NS        = 8;
  localparam int          FAST_RC_START_NS = 1000;
  localparam int          LOW_RC_START_NS  = 8;
  localparam int          POSC_START_NS = 20000;
  localparam int          PLL_LOCK_NS   = 30000;
  localparam int          CNT_W         = 13;
  localparam int          FAST_RC_START_CYC = (FAST_RC_START_NS + CLK_NS - 1) / CLK_NS;
  localparam int          LOW_RC_START_CYC  = (LOW_RC_START_NS + CLK_NS - 1) / CLK_NS;
  localparam int          POSC_START_CYC = (POSC_START_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PLL_START_CYC  = (POSC_START_NS + PLL_LOCK_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {OSC_FAST_RC, OSC_LOW_RC, OSC_POSC, OSC_POSC_PLL} osc_sel_t;

  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_SLEEP, ST_WAKE_WAIT} power_state_t;

  typedef struct packed {
    logic       irq_valid;
    logic [2:0] irq_prio;
    logic       irq_in_sleep;
    logic       watchdog_timeout;
  } wake_req_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic sys_osc_en;
    logic pb_clk_run;
    logic fail_mon_en;
    logic brownout_en;
    logic sleep_domain_en;
    logic io_hold;
  } clk_ctl_t;

endpackage : power_ctl_pkg

// *** rtl/pb_clk_div.sv ***
`timescale 1ns/100ps
module pb_clk_div #(
  parameter int DIV_W = power_ctl_pkg::PBDIV_W,
  parameter int CNT_W = power_ctl_pkg::PBCNT_W
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] ratio,
  // peripheral clock enable
  output logic                  tick
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] mask;
  logic             next_tick;

  always_comb begin
    mask      = CNT_W'((1 << ratio) - 1);
    next_tick = 1'b0;
    next_cnt  = '0;
    if (run) begin
      // a ratio change mid-count keeps the count; a count at or past the new limit ticks at once and restarts from zero
      if (cnt >= mask) begin
        next_tick = 1'b1;
        next_cnt  = '0;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule : pb_clk_div

// *** verification/power_mode_ctl_sva.sv ***
`timescale 1ns/100ps
module power_mode_ctl_sva #(
  parameter int NPERIPH = 16
) (
  // clock and reset
  input wire logic                                  sys_clk,
  input wire logic                                  rst_n,
  input wire logic                                  ce,
  // apb
  input wire logic                                  psel,
  input wire logic                                  penable,
  input wire logic [power_ctl_pkg::ADDR_W-1:0]      paddr,
  input wire logic                                  pready,
  input wire logic                                  pslverr,
  // cpu, interrupts, clock controls
  input wire logic                                  wait_exec,
  input wire logic [2:0]                            cpu_prio,
  input wire power_ctl_pkg::wake_req_t              wake_req,
  input wire power_ctl_pkg::clk_ctl_t               clk_ctl,
  input wire logic [NPERIPH-1:0]                    periph_halt,
  input wire logic                                  cpu_release
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic idle_st;
  logic sleep_st;
  logic hi_irq;
  assign idle_st  = !clk_ctl.cpu_clk_en && clk_ctl.pb_clk_run;
  // also true while waiting for the oscillator, which ignores new wakes
  assign sleep_st = clk_ctl.io_hold;
  assign hi_irq   = wake_req.irq_valid && (wake_req.irq_prio > cpu_prio);

  a_apb_answer: assert property (psel && !penable && ce |=> pready) else $error("no ready after setup");
  a_bad_addr: assert property (psel && !penable && ce && paddr > 8'h08 |=> pslverr) else $error("no error");
  a_wait_halts: assert property (wait_exec && clk_ctl.cpu_clk_en && ce |=> !clk_ctl.cpu_clk_en)
    else $error("wait did not halt cpu");
  a_idle_resume: assert property (idle_st && hi_irq && ce |=> clk_ctl.cpu_clk_en && cpu_release)
    else $error("idle did not resume");
  a_idle_stays: assert property (idle_st && !hi_irq && !wake_req.watchdog_timeout |=> !clk_ctl.cpu_clk_en)
    else $error("idle left without cause");
  a_idle_watchdog: assert property (idle_st && wake_req.watchdog_timeout |=> cpu_release)
    else $error("watchdog did not end idle");
  a_sleep_wake: assert property (sleep_st && hi_irq && wake_req.irq_in_sleep |-> ##[1:8] cpu_release)
    else $error("sleep irq did not wake");
  a_sleep_idle: assert property (sleep_st && !clk_ctl.sys_osc_en && wake_req.irq_valid && wake_req.irq_in_sleep
    && !hi_irq && !wake_req.watchdog_timeout |-> ##[1:8] (idle_st && !clk_ctl.io_hold))
    else $error("low sleep irq did not reach idle");
  a_sleep_watchdog: assert property (sleep_st && wake_req.watchdog_timeout |-> ##[1:8] cpu_release)
    else $error("watchdog did not end sleep");
  a_sleep_off: assert property (!clk_ctl.pb_clk_run |-> !clk_ctl.cpu_clk_en && !clk_ctl.fail_mon_en
    && clk_ctl.io_hold && &periph_halt) else $error("sleep left something on");
  a_idle_osc: assert property (idle_st |-> clk_ctl.sys_osc_en && !clk_ctl.io_hold)
    else $error("idle stopped source");
  a_brownout_on: assert property (clk_ctl.brownout_en && clk_ctl.sleep_domain_en)
    else $error("always-on off");
  a_release_late: assert property (cpu_release |-> clk_ctl.cpu_clk_en && !$past(clk_ctl.cpu_clk_en))
    else $error("release without clock restart");
endmodule : power_mode_ctl_sva

bind power_mode_ctl power_mode_ctl_sva #(.NPERIPH(NPERIPH)) u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .wait_exec(wait_exec),
  .cpu_prio(cpu_prio), .wake_req(wake_req), .clk_ctl(clk_ctl), .periph_halt(periph_halt),
  .cpu_release(cpu_release));

// *** verification/cpu_irq_model.sv ***
`timescale 1ns/100ps
module cpu_irq_model (
  // clock
  input wire logic                 sys_clk,
  // acknowledge from the controller
  input wire logic                 cpu_release,
  // cpu and interrupt controller lines
  output logic                     wait_exec,
  output logic [2:0]               cpu_prio,
  output power_ctl_pkg::wake_req_t wake_req
);
  initial begin
    wait_exec = 1'b0;
    cpu_prio  = 3'h0;
    wake_req  = '0;
  end
  // a request stays pending until the cpu is released to serve it
  always @(posedge sys_clk) if (cpu_release) wake_req <= '0;

  task automatic exec_wait();
    @(posedge sys_clk);
    wait_exec <= 1'b1;
    @(posedge sys_clk);
    wait_exec <= 1'b0;
    #1;
  endtask : exec_wait

  task automatic post_irq(input logic [2:0] p, input logic s, input logic w);
    @(posedge sys_clk);
    wake_req <= '{irq_valid: !w, irq_prio: p, irq_in_sleep: s, watchdog_timeout: w};
  endtask : post_irq

  task automatic set_prio(input logic [2:0] p);
    @(posedge sys_clk);
    cpu_prio <= p;
  endtask : set_prio
endmodule : cpu_irq_model

// *** verification/power_mode_ctl_tb.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module power_mode_ctl_tb;
  logic                      sys_clk, rst_n, ce, psel, penable, pwrite, usb_keep_osc;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata;
  logic                      pready, pslverr, pb_clk_tick, cpu_release, wait_exec;
  logic [2:0]                cpu_prio;
  logic [15:0]               periph_halt;
  power_ctl_pkg::wake_req_t  wake_req;
  power_ctl_pkg::clk_ctl_t   clk_ctl;
  int                        n_fail, total_checks, cyc, n;
  logic [1:0]                osc;
  logic                      usb;
  localparam int DLY [4] = '{3, 1, 4, 5};

  power_mode_ctl #(.FAST_RC_START_CYC(13'd3), .LOW_RC_START_CYC(13'd1), .POSC_START_CYC(13'd4),
    .PLL_START_CYC(13'd5)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_exec(wait_exec), .cpu_prio(cpu_prio), .wake_req(wake_req), .usb_keep_osc(usb_keep_osc),
    .clk_ctl(clk_ctl), .pb_clk_tick(pb_clk_tick), .periph_halt(periph_halt), .cpu_release(cpu_release));

  cpu_irq_model cpu (.sys_clk(sys_clk), .cpu_release(cpu_release), .wait_exec(wait_exec),
    .cpu_prio(cpu_prio), .wake_req(wake_req));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic ex_err);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 50);
    `CHK(pready, 1'b1);
    if (!w) `CHK(prdata, exp);
    `CHK(pslverr, ex_err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  // edges until the cpu is let go, counted from the caller's edge
  task automatic wait_rel(output int c);
    c = 0;
    do begin @(posedge sys_clk); #1; c++; end while (cpu_release !== 1'b1 && c < 50);
  endtask : wait_rel

  task automatic tick_gap(output int g);
    repeat (2) begin
      g = 0;
      do begin @(posedge sys_clk); g++; end while (pb_clk_tick !== 1'b1 && g < 40);
    end
  endtask : tick_gap

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    usb_keep_osc = 1'b0; n_fail = 0; total_checks = 0; cyc = 0; ce = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(1'b0, power_ctl_pkg::OFS_CTRL, 32'h0, power_ctl_pkg::CTRL_RESET, 1'b0);
    acc(1'b0, power_ctl_pkg::OFS_STOP_IDLE, 32'h0, power_ctl_pkg::STOP_IDLE_RESET, 1'b0);
    acc(1'b1, power_ctl_pkg::OFS_STATUS, 32'hffff_ffff, 32'h0, 1'b0);
    acc(1'b0, power_ctl_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
    acc(1'b1, 8'h0c, 32'h1, 32'h0, 1'b1);
    acc(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, power_ctl_pkg::OFS_CTRL, 32'(c) << 1, 32'h0, 1'b0);
      tick_gap(n);
      `CHK(n, 1 << c);
    end
    acc(1'b1, power_ctl_pkg::OFS_CTRL, 32'h0, 32'h0, 1'b0);
    acc(1'b1, power_ctl_pkg::OFS_STOP_IDLE, 32'h0000_a5c3, 32'h0, 1'b0);
    cpu.set_prio(3'd3);
    cpu.exec_wait();
    `CHK(clk_ctl.cpu_clk_en, 1'b0);
    `CHK(clk_ctl.sys_osc_en, 1'b1);
    `CHK(periph_halt, 16'ha5c3);
    cpu.post_irq(3'd3, 1'b0, 1'b0);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(clk_ctl.cpu_clk_en, 1'b0);
    // a frozen clock enable must hold off even a qualifying wake
    @(posedge sys_clk) ce <= 1'b0;
    cpu.set_prio(3'd2);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK({clk_ctl.cpu_clk_en, cpu_release}, 2'b00);
    @(posedge sys_clk) ce <= 1'b1;
    wait_rel(n);
    `CHK(n, 1);
    `CHK(periph_halt, 16'h0);
    cpu.exec_wait();
    cpu.post_irq(3'd0, 1'b0, 1'b1);
    wait_rel(n);
    `CHK(n, 1);
    // four oscillators, then primary with the usb hold
    for (int i = 0; i < 5; i++) begin
      osc = (i < 4) ? 2'(i) : 2'd2;
      usb = (i == 4);
      @(posedge sys_clk) usb_keep_osc <= usb;
      acc(1'b1, power_ctl_pkg::OFS_CTRL, {26'h0, osc, usb, 3'b001}, 32'h0, 1'b0);
      cpu.exec_wait();
      `CHK(clk_ctl, power_ctl_pkg::clk_ctl_t'({1'b0, usb, 5'b00111}));
      `CHK(periph_halt, 16'hffff);
      acc(1'b0, power_ctl_pkg::OFS_STATUS, 32'h0, 32'ha, 1'b0);
      cpu.post_irq(3'd0, 1'b0, 1'b1);
      wait_rel(n);
      `CHK(n, usb ? 1 : DLY[osc] + 1);
    end
    acc(1'b0, power_ctl_pkg::OFS_STATUS, 32'h0, 32'h8, 1'b0);
    usb_keep_osc <= 1'b0;
    acc(1'b1, power_ctl_pkg::OFS_CTRL, 32'h1, 32'h0, 1'b0);
    cpu.set_prio(3'd3);
    cpu.exec_wait();
    cpu.post_irq(3'd5, 1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK(clk_ctl.io_hold, 1'b1);
    cpu.post_irq(3'd2, 1'b1, 1'b0);
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK({clk_ctl.pb_clk_run, clk_ctl.cpu_clk_en, cpu_release}, 3'b100);
    cpu.set_prio(3'd1);
    wait_rel(n);
    `CHK(n, 1);
    cpu.exec_wait();
    cpu.post_irq(3'd4, 1'b1, 1'b0);
    wait_rel(n);
    `CHK(n, DLY[0] + 1);
    // reset in mid-run while asleep
    cpu.exec_wait();
    `CHK(clk_ctl.io_hold, 1'b1);
    @(posedge sys_clk) rst_n <= 1'b0;
    @(posedge sys_clk) rst_n <= 1'b1;
    #1;
    `CHK({clk_ctl, periph_halt}, {7'h7e, 16'h0});
    acc(1'b0, power_ctl_pkg::OFS_CTRL, 32'h0, power_ctl_pkg::CTRL_RESET, 1'b0);
    close_out();
  end
endmodule : power_mode_ctl_tb
